// ==== src/pps_pkg.sv ====
// Package for the port-eight pin function select block.
// Assumes a plain register port with one-cycle strobes and read data one cycle later.
// Notes on behaviour
// - read of output latch returns latch value for bits set as output
// - read of output latch returns sampled pin level for bits set as input
// - latch bits 6..0 reset to zero, bit 7 reserved reads one
// - pin 6 serial mode: clock enables and sync mode choose port or serial clock
// - I2C enable makes pin 6 the I2C clock; software clears serial clock bits
// - relocation select one: pin 6 is I2C clock or plain port
// - interrupt five enable routes pin 6 level to interrupt input five
// - pin 5 is serial receive when relocation zero and receiver enabled
// - interrupt four enable routes pin 5 level to interrupt input four
// - pin 4 is serial transmit when relocation zero and transmitter enabled
// - interrupt three enable routes pin 4 level to interrupt input three
// - pin 3 plain port, also feeds host power-down when any host channel enabled
// - pin 2 plain port, or bidirectional clock-run when any host channel enabled
// - pin 1 drives gate A20 when fast enable set, else port plus A20 input
// - pin 0 drives power event when enabled, else port plus event input
// - direction one drives pin from latch, zero makes it input; bits 6..0 reset zero, bit 7 one
package pps_pkg;
  localparam logic [1:0] PPS_ADDR_LATCH    = 2'h0;
  localparam logic [1:0] PPS_ADDR_DIR      = 2'h1;
  localparam logic [1:0] PPS_ADDR_PINSEL   = 2'h2;
  localparam logic [7:0] PPS_LATCH_RESET   = 8'h80;
  localparam logic [7:0] PPS_DIR_RESET     = 8'h80;
  localparam logic [7:0] PPS_RESERVED_MASK = 8'h80;
  localparam logic [7:0] PPS_PINSEL_RESET  = 8'h00;
  localparam int         PPS_BIT_RELOC     = 0;

  // enable bits owned by other peripherals
  typedef struct packed {
    logic i2c_channel_enable;
    logic serial_clock_enable_high;
    logic serial_clock_enable_low;
    logic serial_sync_mode;
    logic receiver_enable;
    logic transmitter_enable;
    logic interrupt_five_enable;
    logic interrupt_four_enable;
    logic interrupt_three_enable;
    logic host_channel_three_enable;
    logic host_channel_two_enable;
    logic host_channel_one_enable;
    logic legacy_host_interface_enable;
    logic fast_gate_a20_enable;
    logic power_event_enable;
  } pps_enables_t;

  // signals from peripherals toward pins
  typedef struct packed {
    logic serial_clock_out;
    logic serial_transmit_out;
    logic i2c_clock_low;
    logic clock_run_out;
    logic clock_run_oe;
    logic gate_a20_out;
    logic power_event_out;
  } pps_periph_out_t;

  // signals from pins toward peripherals
  typedef struct packed {
    logic serial_clock_in;
    logic i2c_clock_in;
    logic serial_receive_in;
    logic irq5_in;
    logic irq4_in;
    logic irq3_in;
    logic host_power_down_input;
    logic clock_run_in;
    logic gate_a20_in;
    logic power_event_in;
  } pps_periph_in_t;
endpackage

// ==== src/pps_port8.sv ====
// Port-eight pin multiplexer with output latch, direction and relocation registers.
// Assumes pin inputs synchronous to clk_sys and peripherals on the same clock.
`timescale 1ns/1ps
`default_nettype none
module pps_port8
  import pps_pkg::*;
(
  input  wire logic            clk_sys,
  input  wire logic            resetn,
  input  wire logic [1:0]      reg_addr,
  input  wire logic [7:0]      reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic      [7:0]      reg_rdata,
  input  wire logic [6:0]      pin_in,
  output logic      [6:0]      pin_out,
  output logic      [6:0]      pin_oe,
  input  wire pps_enables_t    enables,
  input  wire pps_periph_out_t periph_out,
  output pps_periph_in_t       periph_in
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] latch_q;
  logic [7:0] dir_q;
  logic [7:0] pinsel_q;
  logic [7:0] rdata_d;
  logic [7:0] port_view;
  logic       reloc;
  logic       host_any;

  assign reloc    = pinsel_q[PPS_BIT_RELOC];
  assign host_any = enables.host_channel_three_enable | enables.host_channel_two_enable
                  | enables.host_channel_one_enable;

  // reserved bit 7 is forced to one so a careless write cannot disturb it
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      latch_q <= PPS_LATCH_RESET;
    end else if (reg_wr && reg_addr == PPS_ADDR_LATCH) begin
      latch_q <= reg_wdata | PPS_RESERVED_MASK;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dir_q <= PPS_DIR_RESET;
    end else if (reg_wr && reg_addr == PPS_ADDR_DIR) begin
      dir_q <= reg_wdata | PPS_RESERVED_MASK;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pinsel_q <= PPS_PINSEL_RESET;
    end else if (reg_wr && reg_addr == PPS_ADDR_PINSEL) begin
      pinsel_q <= reg_wdata & 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-bit read view: latch when output, pin level when input
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_view
      assign port_view[gi] = dir_q[gi] ? latch_q[gi] : pin_in[gi];
    end
  endgenerate
  assign port_view[7] = 1'b1;

  always_comb begin
    rdata_d = 8'h00;
    unique case (reg_addr)
      PPS_ADDR_LATCH:  rdata_d = port_view;
      PPS_ADDR_DIR:    rdata_d = dir_q;
      PPS_ADDR_PINSEL: rdata_d = pinsel_q;
      default:         rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive selection; peripheral functions are checked before plain port
  logic [6:0] out_d;
  logic [6:0] oe_d;

  always_comb begin
    out_d = latch_q[6:0];
    oe_d  = dir_q[6:0];
    // pin 6
    if (enables.i2c_channel_enable) begin
      out_d[6] = 1'b0;
      oe_d[6]  = periph_out.i2c_clock_low;
    end else if (!reloc && enables.serial_clock_enable_high) begin
      out_d[6] = 1'b0;
      oe_d[6]  = 1'b0;
    end else if (!reloc && (enables.serial_clock_enable_low || enables.serial_sync_mode)) begin
      out_d[6] = periph_out.serial_clock_out;
      oe_d[6]  = 1'b1;
    end
    // pin 5
    if (!reloc && enables.receiver_enable) begin
      out_d[5] = 1'b0;
      oe_d[5]  = 1'b0;
    end
    // pin 4
    if (!reloc && enables.transmitter_enable) begin
      out_d[4] = periph_out.serial_transmit_out;
      oe_d[4]  = 1'b1;
    end
    // pin 3 stays a plain port, power-down is only a tap
    // pin 2
    if (host_any) begin
      out_d[2] = periph_out.clock_run_out;
      oe_d[2]  = periph_out.clock_run_oe;
    end
    // pin 1
    if (enables.fast_gate_a20_enable) begin
      out_d[1] = periph_out.gate_a20_out;
      oe_d[1]  = 1'b1;
    end
    // pin 0
    if (enables.power_event_enable) begin
      out_d[0] = periph_out.power_event_out;
      oe_d[0]  = 1'b1;
    end
  end

  // registered drive adds one cycle of latency from any setting change
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin_out <= 7'h00;
      pin_oe  <= 7'h00;
    end else begin
      pin_out <= out_d;
      pin_oe  <= oe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // taps toward peripherals; disabled taps idle high (inactive for low-true inputs)
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      periph_in <= '1;
    end else begin
      periph_in.serial_clock_in       <= (!reloc && enables.serial_clock_enable_high
                                          && !enables.i2c_channel_enable) ? pin_in[6] : 1'b1;
      periph_in.i2c_clock_in          <= enables.i2c_channel_enable ? pin_in[6] : 1'b1;
      periph_in.irq5_in               <= enables.interrupt_five_enable ? pin_in[6] : 1'b1;
      periph_in.serial_receive_in     <= (!reloc && enables.receiver_enable) ? pin_in[5] : 1'b1;
      periph_in.irq4_in               <= enables.interrupt_four_enable ? pin_in[5] : 1'b1;
      periph_in.irq3_in               <= enables.interrupt_three_enable ? pin_in[4] : 1'b1;
      periph_in.host_power_down_input <= host_any ? pin_in[3] : 1'b1;
      periph_in.clock_run_in          <= host_any ? pin_in[2] : 1'b1;
      periph_in.gate_a20_in           <= pin_in[1];
      periph_in.power_event_in        <= pin_in[0];
    end
  end

endmodule // pps_port8
`default_nettype wire

// ==== verif/pps_port8_sva.sv ====
// Checker for the port-eight pin select block.
// Assumes it is bound to pps_port8 and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module pps_port8_chk
  import pps_pkg::*;
(
  input wire logic            clk_sys,
  input wire logic            resetn,
  input wire logic [1:0]      reg_addr,
  input wire logic            reg_rd,
  input wire logic [7:0]      reg_rdata,
  input wire logic [6:0]      pin_in,
  input wire logic [6:0]      pin_out,
  input wire logic [6:0]      pin_oe,
  input wire pps_enables_t    enables,
  input wire pps_periph_out_t periph_out,
  input wire pps_periph_in_t  periph_in
);
  logic up_q;
  // taps still hold reset values on the first edge after release
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) up_q <= 1'b0;
    else up_q <= 1'b1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////
  a_latch_bit7_one: assert property (reg_rd && reg_addr == 2'h0 |=> reg_rdata[7])
    else $error("reserved bit low");
  a_irq5_tap: assert property (up_q && $past(enables.interrupt_five_enable)
    |-> periph_in.irq5_in == $past(pin_in[6])) else $error("irq5 tap wrong");
  a_irq4_tap: assert property (up_q && $past(enables.interrupt_four_enable)
    |-> periph_in.irq4_in == $past(pin_in[5])) else $error("irq4 tap wrong");
  a_irq3_tap: assert property (up_q && $past(enables.interrupt_three_enable)
    |-> periph_in.irq3_in == $past(pin_in[4])) else $error("irq3 tap wrong");
  a_host_pd_tap: assert property (up_q && $past(enables.host_channel_two_enable)
    |-> periph_in.host_power_down_input == $past(pin_in[3])) else $error("pd tap wrong");
  a_a20_drive: assert property (up_q && $past(enables.fast_gate_a20_enable)
    |-> pin_oe[1] && pin_out[1] == $past(periph_out.gate_a20_out)) else $error("a20 wrong");
  a_pme_drive: assert property (up_q && $past(enables.power_event_enable)
    |-> pin_oe[0] && pin_out[0] == $past(periph_out.power_event_out)) else $error("pme wrong");
  a_i2c_clock_tap: assert property (up_q && $past(enables.i2c_channel_enable)
    |-> periph_in.i2c_clock_in == $past(pin_in[6])) else $error("scl tap wrong");
endmodule // pps_port8_chk
bind pps_port8 pps_port8_chk u_chk (.clk_sys, .resetn, .reg_addr, .reg_rd, .reg_rdata,
  .pin_in, .pin_out, .pin_oe, .enables, .periph_out, .periph_in);
`default_nettype wire

// ==== verif/pps_pin_model.sv ====
// Board side of port eight: the level each pin shows.
// Assumes the bench gives the board level of every released pin.
`timescale 1ns/1ps
`default_nettype none
module pps_pin_model (
  input  wire logic [6:0] ext_level,
  input  wire logic [6:0] pin_out,
  input  wire logic [6:0] pin_oe,
  output logic      [6:0] pin_in
);
  // a driven pin shows the drive, a released one the board level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // pps_pin_model
`default_nettype wire

// ==== verif/tb_pps_port8.sv ====
// Testbench for the port-eight pin select block.
// Assumes the pin model on the board side and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_pps_port8;
  import pps_pkg::*;
  logic [7:0] reg_wdata, reg_rdata;
  logic [6:0] pin_in, pin_out, pin_oe, ext;
  logic [1:0] reg_addr;
  logic clk_sys, resetn, reg_wr, reg_rd;
  pps_enables_t en;
  pps_periph_out_t po;
  pps_periph_in_t pi;
  int err_total, checks;
  pps_port8 dut (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .pin_in, .pin_out, .pin_oe, .enables(en), .periph_out(po), .periph_in(pi));
  pps_pin_model u_pins (.ext_level(ext), .pin_out, .pin_oe, .pin_in);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk("rdata", exp, reg_rdata);
  endtask
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (3000) @(posedge clk_sys);
    err_total++;
    stop_test();
  end
  initial begin
    {err_total, checks, resetn, reg_addr, reg_wdata, reg_wr, reg_rd, ext} = '0;
    en = '0;
    po = '0;
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(2'h0, 8'h80);
    rd(2'h2, 8'h00);
    rd(2'h3, 8'h00);
    // reserved bit 7 is always written as one, as software must
    wr(2'h0, 8'hD5);
    wr(2'h1, 8'hFF);
    rd(2'h0, 8'hD5);
    settle();
    chk("pin_out", 8'h55, {1'b0, pin_out});
    chk("pin_oe", 8'h7F, {1'b0, pin_oe});
    ext <= 7'h2A;
    wr(2'h1, 8'h80);
    rd(2'h0, 8'hAA);
    @(posedge clk_sys);
    ext <= 7'h0A;
    en.fast_gate_a20_enable <= 1'b1;
    en.power_event_enable <= 1'b1;
    en.transmitter_enable <= 1'b1;
    en.receiver_enable <= 1'b1;
    en.serial_clock_enable_low <= 1'b1;
    {en.interrupt_five_enable, en.interrupt_four_enable, en.interrupt_three_enable} <= 3'h7;
    en.host_channel_two_enable <= 1'b1;
    po.gate_a20_out <= 1'b1;
    po.serial_clock_out <= 1'b1;
    settle();
    chk("pin_oe", 8'h53, {1'b0, pin_oe});
    chk("pin_out", 8'h42, {1'b0, pin_out & pin_oe});
    chk("rx_tap", 8'h00, {7'h00, pi.serial_receive_in});
    wr(2'h2, 8'h01);
    rd(2'h2, 8'h01);
    settle();
    chk("pin_oe", 8'h03, {1'b0, pin_oe});
    chk("rx_tap", 8'h01, {7'h00, pi.serial_receive_in});
    @(posedge clk_sys);
    en.serial_clock_enable_low <= 1'b0;
    en.i2c_channel_enable <= 1'b1;
    po.i2c_clock_low <= 1'b1;
    settle();
    chk("scl", 8'h02, {6'h00, pin_oe[6], pin_out[6]});
    @(posedge clk_sys);
    po.clock_run_oe <= 1'b1;
    po.clock_run_out <= 1'b1;
    settle();
    chk("clkrun", 8'h03, {6'h00, pin_oe[2], pin_out[2]});
    stop_test();
  end
endmodule // tb_pps_port8
`default_nettype wire
